// File: pkg/pipm_pkg.sv
// Function
// - Command bytes 0 and 1 carry the 16-bit setpoint, low byte first.
// - Command byte 2: run permit, stall clear; byte 3: force retract, force extend.
// - Response: position low first, five status flags, three end and band flags.
// - Network object instance accepts allocate connection set service 4BH.
// - Network object instance accepts release connection set service 4CH.
// - Assembly attributes 1 and 2 refused; data attribute 3 get and set.
// - Network attributes 6 to 9 refused; 1 to 5 read only; bus-off setting 00H.
// - Message router has nothing; every request to it is unsupported.
package pipm_pkg;
   localparam logic [7:0] SVC_GET        = 8'h0E;
   localparam logic [7:0] SVC_SET        = 8'h10;
   localparam logic [7:0] SVC_ALLOCATE   = 8'h4B;
   localparam logic [7:0] SVC_RELEASE    = 8'h4C;
   localparam logic [7:0] CLS_ROUTER     = 8'h02;
   localparam logic [7:0] CLS_NETWORK    = 8'h03;
   localparam logic [7:0] CLS_ASSEMBLY   = 8'h04;
   localparam logic [7:0] ATTR_DATA      = 8'h03;
   localparam logic [7:0] ATTR_BUS_OFF_SETTING = 8'h03;
   localparam logic [7:0] ATTR_RO_LAST   = 8'h05;
   localparam logic [7:0] ATTR_FIRST     = 8'h01;
   localparam logic [7:0] BUS_OFF_SETTING_VALUE = 8'h00;
   localparam logic [7:0] INST_ONE       = 8'h01;
   localparam logic [7:0] INST_CLASS     = 8'h00;
   // Bit positions inside the four-byte payloads
   localparam int         BYTE0_LSB       = 0;
   localparam int         BYTE1_LSB       = 8;
   localparam int         CMD_RUN_BIT     = 16;
   localparam int         CMD_CLEAR_BIT   = 17;
   localparam int         CMD_RETRACT_BIT = 24;
   localparam int         CMD_EXTEND_BIT  = 25;
   localparam int         RSP_STATUS_LSB  = 16;
   localparam int         RSP_END_LSB     = 24;
   // Answer codes on the answer port
   localparam logic [1:0] ANS_OK         = 2'h0;
   localparam logic [1:0] ANS_UNSUPP     = 2'h1;
   localparam logic [1:0] ANS_NOTGET     = 2'h2;
   localparam logic [1:0] ANS_NOTSET     = 2'h3;

   typedef struct packed {
      logic [7:0] svc;
      logic [7:0] cls;
      logic [7:0] inst;
      logic [7:0] attr;
   } pipm_req_t;

   typedef struct packed {
      logic       reqOk;
      logic [1:0] code;
      logic       toAlloc;
      logic       toRelease;
      logic       isBusOffSetting;
      logic       getData;
      logic       setData;
   } pipm_ans_t;

   typedef struct packed {
      logic [15:0] positionSetpoint;
      logic        driveRunPermit;
      logic        stallLatchClear;
      logic        forceRetract;
      logic        forceExtend;
   } pipm_cmd_t;

   typedef struct packed {
      logic [15:0] measuredPosition;
      logic        remoteLocal;
      logic        error;
      logic        motorStall;
      logic        illegalInput;
      logic        memoryFault;
      logic        retractEndFlag;
      logic        extendEndFlag;
      logic        deviationWithinBand;
   } pipm_stat_t;
endpackage

// File: verilog/pipm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module pipm_mapper
(
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire logic                cmdValid,
   input  wire logic [31:0]         cmdPayload,
   output logic                     cmdLoaded,
   output pipm_pkg::pipm_cmd_t      cmdOut,
   input  wire pipm_pkg::pipm_stat_t statIn,
   output logic [31:0]              rspPayload,
   input  wire logic                reqValid,
   input  wire pipm_pkg::pipm_req_t req,
   output logic                     ansValid,
   output pipm_pkg::pipm_ans_t      ans,
   output logic [7:0]               ansData,
   output logic                     connAllocated
);
   pipm_pkg::pipm_cmd_t cmd_reg, cmd_next;
   logic [31:0]         rsp_reg, rsp_next;
   logic                loaded_reg, loaded_next;
   pipm_pkg::pipm_ans_t ans_reg, ans_next;
   logic                ansV_reg, ansV_next;
   logic [7:0]          data_reg, data_next;
   logic                alloc_reg, alloc_next;
   pipm_pkg::pipm_ans_t dec;

   // Unpack command payload; unused bits dropped
   always_comb
   begin
      cmd_next    = cmd_reg;
      loaded_next = cmdValid;
      if (cmdValid)
      begin
         cmd_next.positionSetpoint = {cmdPayload[pipm_pkg::BYTE1_LSB +: 8],
                                      cmdPayload[pipm_pkg::BYTE0_LSB +: 8]};
         cmd_next.driveRunPermit   = cmdPayload[pipm_pkg::CMD_RUN_BIT];
         cmd_next.stallLatchClear  = cmdPayload[pipm_pkg::CMD_CLEAR_BIT];
         cmd_next.forceRetract     = cmdPayload[pipm_pkg::CMD_RETRACT_BIT];
         cmd_next.forceExtend      = cmdPayload[pipm_pkg::CMD_EXTEND_BIT];
      end
   end

   // Pack response payload every cycle, spare bits zero
   always_comb
   begin
      rsp_next        = 32'h0000_0000;
      rsp_next[pipm_pkg::BYTE0_LSB +: 16]     = statIn.measuredPosition;
      rsp_next[pipm_pkg::RSP_STATUS_LSB +: 5] = {statIn.memoryFault, statIn.illegalInput,
                         statIn.motorStall, statIn.error, statIn.remoteLocal};
      rsp_next[pipm_pkg::RSP_END_LSB +: 3]    = {statIn.deviationWithinBand,
                         statIn.extendEndFlag, statIn.retractEndFlag};
   end

   // Decode explicit requests against the object model
   always_comb
   begin
      dec = '0;
      dec.code = pipm_pkg::ANS_UNSUPP;
      case (req.cls)
         pipm_pkg::CLS_ROUTER: dec.code = pipm_pkg::ANS_UNSUPP;
         pipm_pkg::CLS_NETWORK:
         begin
            if (req.inst == pipm_pkg::INST_ONE)
            begin
               if (req.svc == pipm_pkg::SVC_ALLOCATE)
               begin
                  dec.code = pipm_pkg::ANS_OK;
                  dec.toAlloc = 1'b1;
               end
               else if (req.svc == pipm_pkg::SVC_RELEASE)
               begin
                  dec.code = pipm_pkg::ANS_OK;
                  dec.toRelease = 1'b1;
               end
               else if (req.attr >= pipm_pkg::ATTR_FIRST && req.attr <= pipm_pkg::ATTR_RO_LAST)
               begin
                  if (req.svc == pipm_pkg::SVC_GET)
                  begin
                     dec.code = pipm_pkg::ANS_OK;
                     dec.isBusOffSetting = (req.attr == pipm_pkg::ATTR_BUS_OFF_SETTING);
                  end
                  else if (req.svc == pipm_pkg::SVC_SET)
                     dec.code = pipm_pkg::ANS_NOTSET;
               end
               else if (req.svc == pipm_pkg::SVC_GET)
                  dec.code = pipm_pkg::ANS_NOTGET;
               else if (req.svc == pipm_pkg::SVC_SET)
                  dec.code = pipm_pkg::ANS_NOTSET;
            end
         end
         pipm_pkg::CLS_ASSEMBLY:
         begin
            if (req.inst == pipm_pkg::INST_ONE)
            begin
               if (req.attr == pipm_pkg::ATTR_DATA && req.svc == pipm_pkg::SVC_GET)
               begin
                  dec.code = pipm_pkg::ANS_OK;
                  dec.getData = 1'b1;
               end
               else if (req.attr == pipm_pkg::ATTR_DATA && req.svc == pipm_pkg::SVC_SET)
               begin
                  dec.code = pipm_pkg::ANS_OK;
                  dec.setData = 1'b1;
               end
               else if (req.svc == pipm_pkg::SVC_GET)
                  dec.code = pipm_pkg::ANS_NOTGET;
               else if (req.svc == pipm_pkg::SVC_SET)
                  dec.code = pipm_pkg::ANS_NOTSET;
            end
         end
         default: dec.code = pipm_pkg::ANS_UNSUPP;
      endcase
      dec.reqOk = (dec.code == pipm_pkg::ANS_OK);
   end

   // Answer and connection state next values
   always_comb
   begin
      ans_next   = ans_reg;
      ansV_next  = reqValid;
      data_next  = data_reg;
      alloc_next = alloc_reg;
      if (reqValid)
      begin
         ans_next  = dec;
         data_next = dec.isBusOffSetting ? pipm_pkg::BUS_OFF_SETTING_VALUE : 8'h00;
         if (dec.toAlloc)
            alloc_next = 1'b1;
         else if (dec.toRelease)
            alloc_next = 1'b0;
      end
   end

   // Register all state
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd_reg    <= '0;
         rsp_reg    <= 32'h0000_0000;
         loaded_reg <= 1'b0;
         ans_reg    <= '0;
         ansV_reg   <= 1'b0;
         data_reg   <= 8'h00;
         alloc_reg  <= 1'b0;
      end
      else
      begin
         cmd_reg    <= cmd_next;
         rsp_reg    <= rsp_next;
         loaded_reg <= loaded_next;
         ans_reg    <= ans_next;
         ansV_reg   <= ansV_next;
         data_reg   <= data_next;
         alloc_reg  <= alloc_next;
      end
   end

   assign cmdOut        = cmd_reg;
   assign rspPayload    = rsp_reg;
   assign cmdLoaded     = loaded_reg;
   assign ans           = ans_reg;
   assign ansValid      = ansV_reg;
   assign ansData       = data_reg;
   assign connAllocated = alloc_reg;

   // Checks
   setpoint_order_a: assert property (@(posedge clock) disable iff (!arst_n)
      cmdValid |=> cmdOut.positionSetpoint == {$past(cmdPayload[15:8]), $past(cmdPayload[7:0])})
      else $error("setpoint byte order wrong");
   ctrl_bits_a: assert property (@(posedge clock) disable iff (!arst_n)
      cmdValid |=> cmdOut.driveRunPermit == $past(cmdPayload[16])
                && cmdOut.stallLatchClear == $past(cmdPayload[17])
                && cmdOut.forceRetract == $past(cmdPayload[24])
                && cmdOut.forceExtend == $past(cmdPayload[25]))
      else $error("control bits misplaced");
   rsp_pack_a: assert property (@(posedge clock) disable iff (!arst_n)
      ##1 rspPayload[15:0] == $past(statIn.measuredPosition)
       && rspPayload[18] == $past(statIn.motorStall)
       && rspPayload[26] == $past(statIn.deviationWithinBand))
      else $error("response packing wrong");
   rsp_spare_a: assert property (@(posedge clock) disable iff (!arst_n)
      rspPayload[31:27] == 5'h00 && rspPayload[23:21] == 3'h0)
      else $error("spare response bits set");
   alloc_svc_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_NETWORK && req.inst == pipm_pkg::INST_ONE
      && req.svc == pipm_pkg::SVC_ALLOCATE |=> ansValid && ans.reqOk && connAllocated)
      else $error("allocate not accepted");
   release_svc_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_NETWORK && req.inst == pipm_pkg::INST_ONE
      && req.svc == pipm_pkg::SVC_RELEASE |=> ansValid && ans.reqOk && !connAllocated)
      else $error("release not accepted");
   asm_attr_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_ASSEMBLY && req.inst == pipm_pkg::INST_ONE
      && req.attr != pipm_pkg::ATTR_DATA && req.svc == pipm_pkg::SVC_GET
      |=> ansValid && ans.code == pipm_pkg::ANS_NOTGET)
      else $error("assembly attribute get allowed");
   asm_data_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_ASSEMBLY && req.inst == pipm_pkg::INST_ONE
      && req.attr == pipm_pkg::ATTR_DATA
      && (req.svc == pipm_pkg::SVC_GET || req.svc == pipm_pkg::SVC_SET)
      |=> ansValid && ans.reqOk && (ans.getData || ans.setData))
      else $error("assembly data access refused");
   net_attr_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_NETWORK && req.svc == pipm_pkg::SVC_SET
      && req.inst == pipm_pkg::INST_ONE |=> !ans.reqOk)
      else $error("network attribute set allowed");
   bus_off_read_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_NETWORK && req.inst == pipm_pkg::INST_ONE
      && req.svc == pipm_pkg::SVC_GET && req.attr == pipm_pkg::ATTR_BUS_OFF_SETTING
      |=> ansValid && ans.reqOk && ansData == pipm_pkg::BUS_OFF_SETTING_VALUE)
      else $error("bus-off setting read wrong");
   router_rej_a: assert property (@(posedge clock) disable iff (!arst_n)
      reqValid && req.cls == pipm_pkg::CLS_ROUTER |=> ans.code == pipm_pkg::ANS_UNSUPP)
      else $error("router request accepted");

   // Main scenarios worth seeing once
   cmd_cov_c: cover property (@(posedge clock) disable iff (!arst_n)
      cmdValid ##1 cmdOut.driveRunPermit);
   alloc_cov_c: cover property (@(posedge clock) disable iff (!arst_n)
      connAllocated ##[1:20] !connAllocated);
   data_cov_c: cover property (@(posedge clock) disable iff (!arst_n)
      ansValid && ans.setData);
   unsupp_cov_c: cover property (@(posedge clock) disable iff (!arst_n)
      ansValid && ans.code == pipm_pkg::ANS_UNSUPP);
endmodule // pipm_mapper
`default_nettype wire

// File: tb/pipm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module pipm_master_model
(
   input  wire logic           clock,
   input  wire logic           cmdLoaded,
   input  wire logic           ansValid,
   output logic                cmdValid,
   output logic [31:0]         cmdPayload,
   output logic                reqValid,
   output pipm_pkg::pipm_req_t req
);
   // Idle bus at time zero
   initial
   begin
      cmdValid = 1'b0;
      cmdPayload = 32'h0;
      reqValid = 1'b0;
      req = 32'h0;
   end

   // Packs one command: fl is {run, stall clear, retract, extend}
   task automatic sendCmd(input logic [15:0] sp, input logic [3:0] fl,
                          input logic [5:0] junk, output bit ok);
      @(negedge clock);
      cmdValid = 1'b1;
      cmdPayload = {junk, fl[0], fl[1], junk, fl[2], fl[3], sp};
      @(negedge clock);
      cmdValid = 1'b0;
      cmdPayload = ~cmdPayload; // Released lines show no stale value
      ok = 1'b0;
      for (int k = 0; k < 3 && !ok; k++)
      begin
         ok = cmdLoaded;
         if (!ok)
            @(negedge clock);
      end
   endtask

   // Issues one object request and waits for its answer
   task automatic sendReq(input pipm_pkg::pipm_req_t r, output bit ok);
      @(negedge clock);
      reqValid = 1'b1;
      req = r;
      @(negedge clock);
      reqValid = 1'b0;
      req = ~r;
      ok = 1'b0;
      for (int k = 0; k < 3 && !ok; k++)
      begin
         ok = ansValid;
         if (!ok)
            @(negedge clock);
      end
   endtask
endmodule // pipm_master_model
`default_nettype wire

// File: tb/polled_io_payload_mapper_test.sv
`timescale 1ns/1ps
`default_nettype none
module polled_io_payload_mapper_test;
   logic                 clock;
   logic                 arst_n;
   logic                 cmdValid;
   logic                 cmdLoaded;
   logic                 reqValid;
   logic                 ansValid;
   logic                 connAllocated;
   logic [31:0]          cmdPayload;
   logic [31:0]          rspPayload;
   logic [7:0]           ansData;
   pipm_pkg::pipm_cmd_t  cmdOut;
   pipm_pkg::pipm_stat_t statIn;
   pipm_pkg::pipm_req_t  req;
   pipm_pkg::pipm_ans_t  ans;
   int                   errorCnt;
   int                   testsRun;

   pipm_mapper dut_u (.clock(clock), .arst_n(arst_n), .cmdValid(cmdValid),
      .cmdPayload(cmdPayload), .cmdLoaded(cmdLoaded), .cmdOut(cmdOut), .statIn(statIn),
      .rspPayload(rspPayload), .reqValid(reqValid), .req(req), .ansValid(ansValid),
      .ans(ans), .ansData(ansData), .connAllocated(connAllocated));
   pipm_master_model mst_u (.clock(clock), .cmdLoaded(cmdLoaded), .ansValid(ansValid),
      .cmdValid(cmdValid), .cmdPayload(cmdPayload), .reqValid(reqValid), .req(req));

   // Free-running clock, 100 ns period
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Counts and reports one comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Prints counts and verdict, then stops
   task automatic giveVerdict();
      $display("comparisons %0d, mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // A handshake that never answered ends the run
   task automatic lost(input bit ok);
      if (!ok)
      begin
         errorCnt++;
         $display("unexpected handshake: expected answer, seen none");
         giveVerdict();
      end
   endtask

   // One request to instance 1, judged on its answer code
   task automatic doReq(input logic [7:0] svc, cls, attr, input logic [1:0] code);
      bit ok;
      mst_u.sendReq({svc, cls, pipm_pkg::INST_ONE, attr}, ok);
      lost(ok);
      chk("answer code", {30'h0, code}, {30'h0, ans.code});
      chk("request ok", {31'h0, code == pipm_pkg::ANS_OK}, {31'h0, ans.reqOk});
      // The answer strobe stands for one cycle only
      @(negedge clock);
      chk("answer pulse", 32'h0, {31'h0, ansValid});
   endtask

   // Each command flag alone, unassigned bits all set
   task automatic cmdMap();
      bit ok;
      for (int i = 0; i < 4; i++)
      begin
         mst_u.sendCmd({8'hC3 ^ 8'(i), 8'h3C}, 4'h1 << i, 6'h3F, ok);
         lost(ok);
         chk("command fields", {12'h0, 8'hC3 ^ 8'(i), 8'h3C, 4'h1 << i}, {12'h0, cmdOut});
         // Load strobe drops and fields hold once the payload is released
         @(negedge clock);
         chk("load pulse", 32'h0, {31'h0, cmdLoaded});
         chk("command held", {12'h0, 8'hC3 ^ 8'(i), 8'h3C, 4'h1 << i}, {12'h0, cmdOut});
      end
   endtask

   // Each status flag alone lands on its own response bit
   task automatic rspMap();
      logic [7:0] f;
      for (int i = 0; i < 8; i++)
      begin
         f = 8'h01 << i;
         statIn = {16'hB7C1 + 16'(i), f};
         @(negedge clock);
         chk("response", {5'h0, f[0], f[1], f[2], 3'h0, f[3], f[4], f[5], f[6], f[7],
             16'hB7C1 + 16'(i)}, rspPayload);
      end
   endtask

   // Allocate twice, then release
   task automatic connMap();
      doReq(pipm_pkg::SVC_ALLOCATE, pipm_pkg::CLS_NETWORK, 8'h00, pipm_pkg::ANS_OK);
      chk("allocated", 32'h3, {30'h0, connAllocated, ans.toAlloc});
      doReq(pipm_pkg::SVC_ALLOCATE, pipm_pkg::CLS_NETWORK, 8'h00, pipm_pkg::ANS_OK);
      doReq(pipm_pkg::SVC_RELEASE, pipm_pkg::CLS_NETWORK, 8'h00, pipm_pkg::ANS_OK);
      chk("released", 32'h1, {30'h0, connAllocated, ans.toRelease});
   endtask

   // Assembly and network attribute access, router refusal
   task automatic objMap();
      for (int a = 1; a < 10; a++)
      begin
         doReq(pipm_pkg::SVC_GET, pipm_pkg::CLS_NETWORK, 8'(a),
               a < 6 ? pipm_pkg::ANS_OK : pipm_pkg::ANS_NOTGET);
         if (a == 3)
            chk("bus-off setting", 32'h100, {23'h0, ans.isBusOffSetting, ansData});
         doReq(pipm_pkg::SVC_SET, pipm_pkg::CLS_NETWORK, 8'(a), pipm_pkg::ANS_NOTSET);
         doReq(pipm_pkg::SVC_GET, pipm_pkg::CLS_ASSEMBLY, 8'(a),
               a == 3 ? pipm_pkg::ANS_OK : pipm_pkg::ANS_NOTGET);
         chk("data get", {31'h0, a == 3}, {31'h0, ans.getData});
         doReq(pipm_pkg::SVC_SET, pipm_pkg::CLS_ASSEMBLY, 8'(a),
               a == 3 ? pipm_pkg::ANS_OK : pipm_pkg::ANS_NOTSET);
         chk("data set", {31'h0, a == 3}, {31'h0, ans.setData});
         doReq(8'h0E + 8'(a * 8), pipm_pkg::CLS_ROUTER, 8'(a), pipm_pkg::ANS_UNSUPP);
      end
   endtask

   // Reset, then every scenario in turn
   initial
   begin
      arst_n = 1'b0;
      statIn = '0;
      errorCnt = 0;
      testsRun = 0;
      repeat (20) @(negedge clock);
      // Every output is cleared while reset is held
      chk("reset outputs", 32'h0, {13'h0, cmdLoaded, ansValid, connAllocated, ans, ansData});
      chk("reset response", 32'h0, rspPayload);
      chk("reset command", 32'h0, {12'h0, cmdOut});
      arst_n = 1'b1;
      cmdMap();
      rspMap();
      connMap();
      objMap();
      giveVerdict();
   end
endmodule // polled_io_payload_mapper_test
`default_nettype wire
